// File: rtl/aots_pkg.sv
// Purpose: shared constants and carrier types for the over-range core
// Assumes: 12-bit two's complement samples, 8-bit thresholds
// Notes: stretch length is 8 << select, counted in device clocks
package aots_pkg;
  localparam int SAMPLE_W = 12;
  localparam int MAG_W = 8;
  localparam int SEL_W = 3;
  localparam int STRETCH_W = 11;
  localparam logic [STRETCH_W-1:0] STRETCH_BASE = 11'h008;
  localparam logic [STRETCH_W-1:0] STRETCH_ZERO = 11'h000;
  localparam logic [SAMPLE_W-1:0] SAMPLE_ZERO = 12'h000;
  localparam logic [MAG_W-1:0] MAG_MAX = 8'h7f;
  localparam logic [1:0] CAL_OFF = 2'h0;
  localparam logic [1:0] CAL_FG = 2'h1;
  localparam logic [1:0] CAL_BG = 2'h2;
  localparam logic [MAG_W-1:0] MAG_MIN = 8'h80;
  localparam logic [SAMPLE_W-1:0] MARK_MASK = 12'h010;
  localparam logic [6:0] CAL_LEN = 7'h40;
  localparam logic [1:0] TRIG_IDLE = 2'h1;

  // one sample pair, one code for each output stream
  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
  } aots_pair_type;

  // programmed over-range configuration
  typedef struct packed {
    logic [MAG_W-1:0] high_thr;
    logic [MAG_W-1:0] low_thr;
    logic [SEL_W-1:0] sel;
  } aots_ovr_cfg_type;
endpackage

// File: rtl/aots_ovr_chan.sv
// Purpose: over-range detect and pulse stretch for one sample stream
// Assumes: sample is registered on the same clock
// Notes: two flags, index 0 high threshold, index 1 low threshold
`timescale 1ns/10ps
module aots_ovr_chan
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic valid_in,
  input wire logic [aots_pkg::SAMPLE_W-1:0] sample_in,
  input wire aots_pkg::aots_ovr_cfg_type cfg_in,
  output logic [1:0] flag_out
);
  logic [aots_pkg::MAG_W-1:0] top_bits;
  logic [aots_pkg::MAG_W-1:0] mag;
  logic [aots_pkg::MAG_W-1:0] thr [2];
  logic [aots_pkg::STRETCH_W-1:0] load_len;

  // upper eight bits, magnitude saturating -128 to 127
  assign top_bits = sample_in[aots_pkg::SAMPLE_W-1 -: aots_pkg::MAG_W];
  assign mag = (top_bits == aots_pkg::MAG_MIN) ? aots_pkg::MAG_MAX :
    (top_bits[7] ? 8'(-top_bits) : top_bits);
  assign thr[0] = cfg_in.high_thr;
  assign thr[1] = cfg_in.low_thr;
  assign load_len = aots_pkg::STRETCH_BASE << cfg_in.sel;

  // per-threshold stretch counter, restarted by each hit
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_thr
      logic [aots_pkg::STRETCH_W-1:0] cnt_q;
      logic [aots_pkg::STRETCH_W-1:0] cnt_d;
      logic hit;
      assign hit = valid_in && (mag >= thr[gi]);
      assign cnt_d = hit ? load_len :
        (cnt_q != aots_pkg::STRETCH_ZERO ? cnt_q - 11'h001 : cnt_q);
      always_ff @(posedge mclk_in)
      begin
        if (srst_in)
        begin
          cnt_q <= aots_pkg::STRETCH_ZERO;
          flag_out[gi] <= 1'b0;
        end
        else
        begin
          cnt_q <= cnt_d;
          flag_out[gi] <= (cnt_d != aots_pkg::STRETCH_ZERO);
        end
      end
    end
  endgenerate
endmodule

// File: rtl/aots_core.sv
// Purpose: digital side of a dual or single channel sampling core
// Assumes: converted codes arrive per edge as 12-bit two's complement
// Notes: analog path, link and clock trim are outside this block
// Notes: the marker trails its trigger by the two synchroniser stages
// Notes: a calibration start with mode 0 or 3 is ignored
`timescale 1ns/10ps
module aots_core
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic single_mode_in,
  input wire logic [aots_pkg::SAMPLE_W-1:0] rise_code_a_in,
  input wire logic [aots_pkg::SAMPLE_W-1:0] rise_code_b_in,
  input wire logic [aots_pkg::SAMPLE_W-1:0] fall_code_in,
  input wire logic [aots_pkg::MAG_W-1:0] high_overrange_threshold_in,
  input wire logic [aots_pkg::MAG_W-1:0] low_overrange_threshold_in,
  input wire logic [aots_pkg::SEL_W-1:0] overrange_stretch_select_in,
  input wire logic marker_enable_in,
  input wire logic marker_trigger_in_pos,
  input wire logic marker_trigger_in_neg,
  input wire logic [1:0] cal_mode_in,
  input wire logic cal_start_in,
  output logic [aots_pkg::SAMPLE_W-1:0] sample_a_out,
  output logic [aots_pkg::SAMPLE_W-1:0] sample_b_out,
  output logic sample_valid_out,
  output logic chan_a_high_flag_pin_out,
  output logic chan_a_low_flag_pin_out,
  output logic chan_b_high_flag_pin_out,
  output logic chan_b_low_flag_pin_out,
  output logic cal_busy_out
);
  // capture, trigger and calibration state
  aots_pkg::aots_pair_type cap_q;
  aots_pkg::aots_pair_type cap_d;
  aots_pkg::aots_ovr_cfg_type cfg;
  logic cap_valid_q;
  logic [1:0] trig_meta_q;
  logic [1:0] trig_sync_q;
  logic trig_cap_q;
  logic trig_level;
  logic cal_go;
  logic [6:0] cal_cnt_q;
  logic cal_fg_q;
  logic cal_bg_q;
  logic sampling_on;
  logic [1:0] flag_a;
  logic [1:0] flag_b;
  logic [aots_pkg::SAMPLE_W-1:0] mark_a;
  logic [aots_pkg::SAMPLE_W-1:0] mark_b;
  logic [aots_pkg::SAMPLE_W-1:0] mark_bits;
  logic [aots_pkg::SAMPLE_W-1:0] out_a;
  logic [aots_pkg::SAMPLE_W-1:0] out_b;

  // each leg synchronised on its own; gating them first would let a
  // skewed edge between the legs glitch into the meta flop
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      trig_meta_q <= aots_pkg::TRIG_IDLE;
      trig_sync_q <= aots_pkg::TRIG_IDLE;
    end
    else
    begin
      trig_meta_q <= {marker_trigger_in_pos, marker_trigger_in_neg};
      trig_sync_q <= trig_meta_q;
    end
  end

  // differential level decoded only once both legs are settled
  assign trig_level = trig_sync_q[1] & ~trig_sync_q[0];

  // foreground calibration stops sampling; background keeps it running
  assign sampling_on = ~cal_fg_q;

  // a start counts only when idle and with a mode that does something
  assign cal_go = cal_start_in && !cal_fg_q && !cal_bg_q &&
    (cal_mode_in == aots_pkg::CAL_FG || cal_mode_in == aots_pkg::CAL_BG);

  // calibration sequencer, fixed length countdown
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      cal_cnt_q <= 7'h00;
      cal_fg_q <= 1'b0;
      cal_bg_q <= 1'b0;
    end
    else if (cal_go)
    begin
      cal_cnt_q <= aots_pkg::CAL_LEN;
      cal_fg_q <= (cal_mode_in == aots_pkg::CAL_FG);
      cal_bg_q <= (cal_mode_in == aots_pkg::CAL_BG);
    end
    else if (cal_cnt_q != 7'h00)
    begin
      cal_cnt_q <= cal_cnt_q - 7'h01;
      if (cal_cnt_q == 7'h01)
      begin
        cal_fg_q <= 1'b0;
        cal_bg_q <= 1'b0;
      end
    end
  end

  // dual mode: both rising codes; single mode: rising then falling
  assign cap_d.a = rise_code_a_in;
  assign cap_d.b = single_mode_in ? fall_code_in : rise_code_b_in;

  // capture stage; codes stay two's complement end to end
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      cap_q <= '0;
      cap_valid_q <= 1'b0;
      trig_cap_q <= 1'b0;
    end
    else
    begin
      cap_q <= cap_d;
      cap_valid_q <= sampling_on;
      trig_cap_q <= trig_level;
    end
  end

  // one threshold set shared by both channels
  assign cfg.high_thr = high_overrange_threshold_in;
  assign cfg.low_thr = low_overrange_threshold_in;
  assign cfg.sel = overrange_stretch_select_in;

  aots_ovr_chan u_ovr_a
  (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .valid_in(cap_valid_q),
    .sample_in(cap_q.a),
    .cfg_in(cfg),
    .flag_out(flag_a)
  );

  aots_ovr_chan u_ovr_b
  (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .valid_in(cap_valid_q),
    .sample_in(cap_q.b),
    .cfg_in(cfg),
    .flag_out(flag_b)
  );

  // marker replaces the LSB of the 8-bit view, bit 4 of the word
  assign mark_bits = trig_cap_q ? aots_pkg::MARK_MASK :
    aots_pkg::SAMPLE_ZERO;
  assign mark_a = marker_enable_in ?
    ((cap_q.a & ~aots_pkg::MARK_MASK) | mark_bits) : cap_q.a;
  assign mark_b = marker_enable_in ?
    ((cap_q.b & ~aots_pkg::MARK_MASK) | mark_bits) : cap_q.b;

  // invalid cycles show zero so a stopped core never leaks stale codes
  assign out_a = cap_valid_q ? mark_a : aots_pkg::SAMPLE_ZERO;
  assign out_b = cap_valid_q ? mark_b : aots_pkg::SAMPLE_ZERO;

  // sample outputs and their valid strobe
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      sample_a_out <= aots_pkg::SAMPLE_ZERO;
      sample_b_out <= aots_pkg::SAMPLE_ZERO;
      sample_valid_out <= 1'b0;
    end
    else
    begin
      sample_a_out <= out_a;
      sample_b_out <= out_b;
      sample_valid_out <= cap_valid_q;
    end
  end

  // flag pins; one cycle behind the stretch counters
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      chan_a_high_flag_pin_out <= 1'b0;
      chan_a_low_flag_pin_out <= 1'b0;
      chan_b_high_flag_pin_out <= 1'b0;
      chan_b_low_flag_pin_out <= 1'b0;
    end
    else
    begin
      chan_a_high_flag_pin_out <= flag_a[0];
      chan_a_low_flag_pin_out <= flag_a[1];
      chan_b_high_flag_pin_out <= flag_b[0];
      chan_b_low_flag_pin_out <= flag_b[1];
    end
  end

  // busy covers both calibration kinds; a pin, so it is registered
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      cal_busy_out <= 1'b0;
    end
    else
    begin
      cal_busy_out <= cal_fg_q | cal_bg_q;
    end
  end
endmodule

// File: bench/aots_sva.sv
// Purpose: port-level timing checks for the over-range core
// Assumes: thresholds held steady while hits are checked
// Notes: only the channel A high flag is tied to its cause here
`timescale 1ns/10ps
module aots_sva
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic [11:0] rise_code_a_in,
  input wire logic [7:0] high_overrange_threshold_in,
  input wire logic marker_enable_in,
  input wire logic [1:0] cal_mode_in,
  input wire logic cal_start_in,
  input wire logic [11:0] sample_a_out,
  input wire logic sample_valid_out,
  input wire logic chan_a_high_flag_pin_out,
  input wire logic cal_busy_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (srst_in);
  // -128 saturates, so no hit is lost on the most negative code
  function automatic logic [7:0] mag(logic [7:0] c);
    mag = c[7] ? ((c == 8'h80) ? 8'h7f : -c) : c;
  endfunction
  wire hit = mag(rise_code_a_in[11:4]) >= high_overrange_threshold_in;
  AST_HIT: assert property (hit && !cal_busy_out && !cal_start_in
    && !$past(cal_start_in) && !marker_enable_in
    |-> ##3 chan_a_high_flag_pin_out)
    else $error("high flag missed a hit");
  AST_CAUSE: assert property ($rose(chan_a_high_flag_pin_out)
    |-> $past(hit, 3)) else $error("high flag rose without a hit");
  AST_STRETCH: assert property ($rose(chan_a_high_flag_pin_out)
    |-> chan_a_high_flag_pin_out[*8]) else $error("flag pulse too short");
  AST_SAMPLE: assert property (sample_valid_out |->
    {sample_a_out[11:5], sample_a_out[3:0]} ==
    $past({rise_code_a_in[11:5], rise_code_a_in[3:0]}, 2))
    else $error("sample a not the code two cycles back");
  AST_ZERO: assert property (!sample_valid_out |->
    sample_a_out == 12'h000) else $error("sample not zero while invalid");
  AST_CAL: assert property (cal_start_in && !cal_busy_out &&
    cal_mode_in != 2'h0 |-> ##[1:2] cal_busy_out)
    else $error("calibration did not start");
  AST_FG: assert property ($past(cal_busy_out) && cal_busy_out &&
    cal_mode_in == 2'h1 |-> !sample_valid_out)
    else $error("valid during foreground calibration");
  AST_RESET: assert property ($past(srst_in) |->
    !chan_a_high_flag_pin_out && !cal_busy_out)
    else $error("outputs not quiet after reset");
endmodule
bind aots_core aots_sva u_sva (.mclk_in, .srst_in, .rise_code_a_in,
  .high_overrange_threshold_in, .marker_enable_in, .cal_mode_in,
  .cal_start_in, .sample_a_out, .sample_valid_out,
  .chan_a_high_flag_pin_out, .cal_busy_out);

// File: bench/aots_mon.sv
// Purpose: downstream logic watching the four over-range pins
// Assumes: single mode, where both streams share one input
// Notes: the OR adds no latency; gain requests follow the OR'd flags
`timescale 1ns/10ps
module aots_mon
#(
  parameter int QUIET_LEN = 16
)
(
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic a_high_in,
  input wire logic a_low_in,
  input wire logic b_high_in,
  input wire logic b_low_in,
  output logic or_high_out,
  output logic or_low_out,
  output logic gain_up_out,
  output logic gain_down_out
);
  int quiet_q;
  // either stream may carry the crossing, so both pins count
  assign or_high_out = a_high_in | b_high_in;
  assign or_low_out = a_low_in | b_low_in;
  // a long quiet low flag means a weak signal: ask for more gain
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || or_low_out)
      quiet_q <= 0;
    else if (quiet_q < QUIET_LEN)
      quiet_q <= quiet_q + 1;
  end
  assign gain_up_out = (quiet_q == QUIET_LEN);
  assign gain_down_out = or_high_out;
endmodule

// File: bench/tb_top.sv
// Purpose: directed checks of samples, flags, marker and calibration
// Assumes: high threshold 0x60, low threshold 0x20
// Notes: inputs change on the falling edge only
`timescale 1ns/10ps
module tb_top;
  logic mclk_in = 0, srst_in = 1, single_mode_in = 0, cal_start_in = 0;
  logic marker_enable_in = 0, marker_trigger_in_pos = 0;
  logic marker_trigger_in_neg = 1;
  logic [11:0] rise_code_a_in = 0, rise_code_b_in = 0, fall_code_in = 0;
  logic [2:0] overrange_stretch_select_in = 0;
  logic [1:0] cal_mode_in = 0;
  logic [11:0] sample_a_out, sample_b_out;
  logic sample_valid_out, cal_busy_out, ah, al, bh, bl, or_high, or_low;
  logic gain_up, gain_down;
  int bad_count = 0, compares = 0, cyc = 0, n;
  aots_core u_dut (.mclk_in, .srst_in, .single_mode_in, .rise_code_a_in,
    .rise_code_b_in, .fall_code_in, .high_overrange_threshold_in(8'h60),
    .low_overrange_threshold_in(8'h20), .overrange_stretch_select_in,
    .marker_enable_in, .marker_trigger_in_pos, .marker_trigger_in_neg,
    .cal_mode_in, .cal_start_in, .sample_a_out, .sample_b_out,
    .sample_valid_out, .chan_a_high_flag_pin_out(ah),
    .chan_a_low_flag_pin_out(al), .chan_b_high_flag_pin_out(bh),
    .chan_b_low_flag_pin_out(bl), .cal_busy_out);
  aots_mon u_mon (.mclk_in, .srst_in, .a_high_in(ah), .a_low_in(al),
    .b_high_in(bh), .b_low_in(bl), .or_high_out(or_high),
    .or_low_out(or_low), .gain_up_out(gain_up), .gain_down_out(gain_down));
  initial forever #12.5 mclk_in = ~mclk_in;
  // hang guard, well above the roughly 10k cycles the run needs
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  task finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(string s, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e)
    begin
      bad_count++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  task tick(int k);
    repeat (k) @(negedge mclk_in);
  endtask
  // hold codes long enough that old stretches have run out
  task steady(logic [11:0] a, b, f, logic [3:0] e);
    rise_code_a_in = a;
    rise_code_b_in = b;
    fall_code_in = f;
    tick(12);
    chk("pins", {8'h00, e}, {8'h00, ah, al, bh, bl});
  endtask
  // hit at cycle 0 and optionally at cycle gap, count flag-high cycles
  task pulse(int gap, output int cnt);
    cnt = 0;
    for (int i = 0; i < 1100; i++)
    begin
      rise_code_a_in = (i == 0 || i == gap) ? 12'h800 : 12'h000;
      tick(1);
      cnt += (ah === 1'b1);
    end
  endtask
  initial
  begin
    tick(20);
    srst_in = 0;
    tick(2);
    steady(12'h123, 12'h7ff, 12'h000, 4'h3);
    chk("sample_a", 12'h123, sample_a_out);
    chk("sample_b", 12'h7ff, sample_b_out);
    steady(12'h800, 12'h000, 12'h000, 4'hc);
    steady(12'h600, 12'h5f0, 12'h000, 4'hd);
    steady(12'h300, 12'ha00, 12'h000, 4'h7);
    single_mode_in = 1;
    steady(12'h000, 12'h000, 12'h900, 4'h3);
    chk("sample_b", 12'h900, sample_b_out);
    chk("or_flags", 12'h003, {10'h000, or_high, or_low});
    chk("gain_up", 12'h000, {11'h000, gain_up});
    chk("gain_down", 12'h001, {11'h000, gain_down});
    single_mode_in = 0;
    for (int s = 0; s < 8; s++)
    begin
      overrange_stretch_select_in = 3'(s);
      pulse(0, n);
      chk("stretch", 12'h008 << s, 12'(n));
    end
    overrange_stretch_select_in = 0;
    pulse(5, n);
    chk("restart", 12'h00d, 12'(n));
    marker_enable_in = 1;
    marker_trigger_in_pos = 1;
    marker_trigger_in_neg = 0;
    steady(12'h000, 12'h000, 12'h000, 4'h0);
    chk("marker_on", 12'h001, {11'h000, sample_a_out[4]});
    marker_trigger_in_pos = 0;
    marker_trigger_in_neg = 1;
    tick(8);
    chk("marker_off", 12'h000, {11'h000, sample_a_out[4]});
    marker_enable_in = 0;
    marker_trigger_in_pos = 1;
    marker_trigger_in_neg = 0;
    tick(8);
    chk("marker_dis", 12'h000, {11'h000, sample_a_out[4]});
    chk("gain_up", 12'h001, {11'h000, gain_up});
    chk("gain_down", 12'h000, {11'h000, gain_down});
    // foreground drops valid, background keeps it
    for (int m = 1; m < 3; m++)
    begin
      cal_mode_in = 2'(m);
      cal_start_in = 1;
      tick(1);
      cal_start_in = 0;
      tick(4);
      chk("busy", 12'h001, {11'h000, cal_busy_out});
      chk("valid", 12'(m == 2), {11'h000, sample_valid_out});
      tick(70);
      chk("idle", 12'h000, {11'h000, cal_busy_out});
      chk("valid_back", 12'h001, {11'h000, sample_valid_out});
    end
    finish_test();
  end
endmodule
